/* snf_pkg.sv */
`default_nettype none
package snf_pkg;

	// ************************************************************
	// serial opcodes understood by the front end
	// ************************************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_GETF = 8'h0f;
	localparam logic [7:0] OP_SETF = 8'h1f;
	localparam logic [7:0] OP_RD1  = 8'h03;
	localparam logic [7:0] OP_RD1F = 8'h0b;
	localparam logic [7:0] OP_RD2  = 8'h3b;
	localparam logic [7:0] OP_RD4  = 8'h6b;
	localparam logic [7:0] OP_PL1  = 8'h02;
	localparam logic [7:0] OP_PL4  = 8'h32;
	localparam logic [7:0] OP_PRD  = 8'h13;
	localparam logic [7:0] OP_PEX  = 8'h10;

	// ************************************************************
	// feature addresses, bit positions, values after reset
	// ************************************************************
	localparam logic [7:0] FA_LOCK        = 8'ha0;
	localparam logic [7:0] FA_CFG         = 8'hb0;
	localparam logic [7:0] FA_STAT        = 8'hc0;
	localparam logic [7:0] FA_DIE         = 8'hd0;
	localparam logic [7:0] LOCK_RST       = 8'h00;
	localparam logic [7:0] CFG_RST        = 8'h10;
	localparam logic [7:0] DIE_RST        = 8'h00;
	localparam logic [7:0] LOCK_KEEP_MASK = 8'hfc;
	localparam int         LOCK_WD_BIT    = 7;
	localparam int         WPH_DIS_BIT    = 1;
	localparam int         ECC_BIT        = 4;
	localparam int         OTP_BIT        = 6;
	localparam int         DIE_LSB        = 6;

	// ************************************************************
	// array organisation
	// ************************************************************
	localparam logic [11:0] MAIN_BYTES       = 12'h800;
	localparam logic [11:0] SPARE_BYTES      = 12'h080;
	localparam logic [11:0] PAGE_BYTES       = MAIN_BYTES + SPARE_BYTES;
	localparam int          PAGES_PER_BLOCK  = 64;
	localparam int          BLOCKS_PER_PLANE = 1024;
	localparam int          NUM_PLANES       = 2;
	localparam int          PLANE_BIT        = $clog2(PAGES_PER_BLOCK);
	localparam logic [23:0] OTP_PAGES        = 24'h00001e;

	// ************************************************************
	// apb register offsets and array request codes
	// ************************************************************
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam logic [7:0] REG_ROW   = 8'h08;
	localparam logic [7:0] REG_ACOL  = 8'h0c;
	localparam logic [7:0] REG_ADATA = 8'h10;
	localparam logic [7:0] REG_DONE  = 8'h14;
	localparam logic [7:0] REG_FEAT  = 8'h18;
	localparam logic [1:0] AOP_NONE  = 2'h0;
	localparam logic [1:0] AOP_LOAD  = 2'h1;
	localparam logic [1:0] AOP_PROG  = 2'h2;

	typedef enum logic [5:0] {
		PH_CMD   = 6'h01,
		PH_ADDR  = 6'h02,
		PH_DUMMY = 6'h04,
		PH_DIN   = 6'h08,
		PH_DOUT  = 6'h10,
		PH_SKIP  = 6'h20
	} snf_phase_t;

endpackage
`default_nettype wire

/* snf_front.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - no command before first select falling edge
// RULE2 - host keeps select low through write sequence
// RULE3 - sample on rising, shift out on falling
// RULE4 - host holds clock static while deselected
// RULE5 - deselected means output lane high impedance
// RULE6 - standby when deselected and not busy
// RULE7 - write protect freezes protect level, top/bottom
// RULE8 - host releases lanes during multi-lane reads
// RULE9 - hold disabled until enabled
// RULE10 - hold only when selected, output tristated
// RULE11 - hold starts on hold fall, clock low
// RULE12 - hold ends on hold rise, clock low
// RULE13 - deselected: lanes 0,2 in, 1,3 out; snf_front leaves all four lanes undriven while deselected
// RULE14 - correction enabled at power-up, switchable
// RULE15 - correction applied on program and load
// RULE16 - host does correction when disabled
// RULE17 - pages 2176 bytes, 64 pages, 1024 blocks
// RULE18 - row bit 6 picks plane
// RULE19 - die chosen by die feature register
// RULE20 - whole-page transfers, cache buffers interface data
// RULE21 - thirty page one-time programmable area
// RULE22 - first page auto-loads after power-up
// RULE23 - clock idles per mode 0 or 3
// RULE24 - protected lock bits 7:2 stay unchanged
// RULE25 - select rising ends and discards frame
// RULE26 - extra lanes driven only in read data
module snf_front (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic [3:0]  lane_in,
	output var  logic [3:0]  lane_out,
	output var  logic [3:0]  lane_oe_n,
	output var  logic        standby,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);

	typedef struct packed {
		logic                 cs_s1;
		logic                 cs_s2;
		logic                 cs_q;
		logic                 sck_s1;
		logic                 sck_s2;
		logic                 sck_q;
		logic [3:0]           ln_s1;
		logic [3:0]           ln_s2;
		logic                 hold_q;
		logic                 armed;
		snf_pkg::snf_phase_t  phase;
		logic [7:0]           op;
		logic [7:0]           sh;
		logic [7:0]           osh;
		logic [3:0]           bitcnt;
		logic [3:0]           ocnt;
		logic [2:0]           w;
		logic [1:0]           abytes;
		logic [23:0]          addr;
		logic [23:0]          row;
		logic [11:0]          col;
		logic [11:0]          acol;
		logic [11:0]          wr_col;
		logic [7:0]           wr_data;
		logic [7:0]           feat;
		logic                 wr_pend;
		logic                 exec_pend;
		logic                 hold_en;
		logic                 hold_act;
		logic                 hold_on_pend;
		logic                 hold_off_pend;
		logic [7:0]           lock;
		logic [7:0]           cfg;
		logic [7:0]           die;
		logic                 wel;
		logic                 oip;
		logic                 p_fail;
		logic [1:0]           aop;
		logic [3:0]           lane_out;
		logic [3:0]           lane_oe_n;
		logic                 standby;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
	} snf_state_t;

	snf_state_t st;
	snf_state_t n;

	logic [7:0]  cache_mem [0:snf_pkg::PAGE_BYTES-1];
	logic [7:0]  spi_rd;
	logic [7:0]  apb_rd;
	logic [7:0]  feat_val;
	logic [7:0]  nb;
	logic [7:0]  ob;
	logic [23:0] a_full;
	logic        sel;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        hold_fall;
	logic        hold_rise;
	logic        live;
	logic        byte_done;
	logic        lock_frozen;
	logic        lock_wr_try;
	logic        apb_acc;
	logic        apb_data_wr;
	logic        mem_we;
	logic [11:0] mem_wa;
	logic [7:0]  mem_wd;
	logic        plane_sel;

	// ************************************************************
	// helper functions
	// ************************************************************

	// shift w lanes into a byte, msb first
	function automatic logic [7:0] shin(input logic [7:0] s, input logic [3:0] l,
		input logic [2:0] w);
		case (w)
			3'h4:    shin = {s[3:0], l};
			3'h2:    shin = {s[5:0], l[1:0]};
			default: shin = {s[6:0], l[0]};
		endcase
	endfunction

	// top bits of a byte placed on the lanes of the given width
	function automatic logic [3:0] lanes_of(input logic [7:0] b, input logic [2:0] w);
		case (w)
			3'h4:    lanes_of = b[7:4];
			3'h2:    lanes_of = {2'h0, b[7:6]};
			default: lanes_of = {2'h0, b[7], 1'h0};
		endcase
	endfunction

	// column step with wrap at end of page
	function automatic logic [11:0] next_col(input logic [11:0] c);
		next_col = (c >= snf_pkg::PAGE_BYTES - 12'h001) ? 12'h000 : c + 12'h001;
	endfunction

	// data lane count of an opcode
	function automatic logic [2:0] width_of(input logic [7:0] op);
		if (op == snf_pkg::OP_RD4 || op == snf_pkg::OP_PL4)
			width_of = 3'h4;
		else if (op == snf_pkg::OP_RD2)
			width_of = 3'h2;
		else
			width_of = 3'h1;
	endfunction

	// ************************************************************
	// edge detection and shared decodes
	// ************************************************************
	assign sel         = ~st.cs_s2;
	assign sck_rise    = st.sck_s2 & ~st.sck_q;
	assign sck_fall    = ~st.sck_s2 & st.sck_q;
	assign cs_fall     = ~st.cs_s2 & st.cs_q;
	assign cs_rise     = st.cs_s2 & ~st.cs_q;
	assign hold_fall   = ~st.ln_s2[3] & st.hold_q;
	assign hold_rise   = st.ln_s2[3] & ~st.hold_q;
	assign live        = sel & st.armed & ~st.hold_act; // [RULE1] [RULE10]
	assign byte_done   = (st.bitcnt + {1'h0, st.w}) == 4'h8;
	assign nb          = shin(st.sh, st.ln_s2, st.w); // [RULE3]
	assign a_full      = {st.addr[15:0], nb};
	assign lock_frozen = st.lock[snf_pkg::LOCK_WD_BIT] & ~st.ln_s2[2]
		& ~st.lock[snf_pkg::WPH_DIS_BIT]; // [RULE7] [RULE24]
	assign lock_wr_try = live & sck_rise & (st.phase == snf_pkg::PH_DIN) & byte_done
		& (st.op == snf_pkg::OP_SETF) & (st.feat == snf_pkg::FA_LOCK);
	assign apb_acc     = psel & penable & st.pready;
	assign apb_data_wr = apb_acc & pwrite & (paddr == snf_pkg::REG_ADATA);
	assign plane_sel   = (snf_pkg::NUM_PLANES > 1) ? st.row[snf_pkg::PLANE_BIT] : 1'h0; // [RULE18]
	assign spi_rd      = cache_mem[st.col];
	assign apb_rd      = cache_mem[st.acol];
	assign ob          = (st.op == snf_pkg::OP_GETF) ? feat_val : spi_rd;

	// feature readback
	always_comb
	begin
		unique case (st.feat)
			snf_pkg::FA_LOCK: feat_val = st.lock;
			snf_pkg::FA_CFG:  feat_val = st.cfg;
			snf_pkg::FA_STAT: feat_val = {4'h0, st.p_fail, 1'h0, st.wel, st.oip};
			snf_pkg::FA_DIE:  feat_val = st.die;
			default:          feat_val = 8'h00;
		endcase
	end

	// ************************************************************
	// cache register, apb port wins, spi byte waits one slot
	// ************************************************************
	assign mem_we = apb_data_wr | st.wr_pend; // [RULE20]
	assign mem_wa = apb_data_wr ? st.acol : st.wr_col;
	assign mem_wd = apb_data_wr ? pwdata[7:0] : st.wr_data;

	// cache write port
	always_ff @(posedge sys_clk)
	begin
		if (mem_we)
			cache_mem[mem_wa] <= mem_wd;
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		n = st;
		// pin synchronisers
		n.cs_s1  = cs_n;
		n.cs_s2  = st.cs_s1;
		n.sck_s1 = sck;
		n.sck_s2 = st.sck_s1;
		n.ln_s1  = lane_in;
		n.ln_s2  = st.ln_s1;
		n.cs_q   = st.cs_s2;
		n.sck_q  = st.sck_s2;
		n.hold_q = st.ln_s2[3];
		if (!apb_data_wr)
			n.wr_pend = 1'h0;

		// apb setup: answer registered for the access cycle
		n.pready  = psel & ~penable;
		n.pslverr = 1'h0;
		n.prdata  = 32'h0;
		if (psel && !penable)
		begin
			unique case (paddr)
				snf_pkg::REG_CTRL:  n.prdata = {31'h0, st.hold_en};
				snf_pkg::REG_STAT:  n.prdata = {21'h0, st.die[7:6], plane_sel,
					st.cfg[snf_pkg::OTP_BIT], st.cfg[snf_pkg::ECC_BIT], st.aop, st.oip,
					st.hold_act, st.armed, sel}; // [RULE15] [RULE19]
				snf_pkg::REG_ROW:   n.prdata = {8'h0, st.row};
				snf_pkg::REG_ACOL:  n.prdata = {20'h0, st.acol};
				snf_pkg::REG_ADATA: n.prdata = {24'h0, apb_rd};
				snf_pkg::REG_DONE:  n.prdata = {29'h0, st.p_fail, st.wel, st.oip};
				snf_pkg::REG_FEAT:  n.prdata = {8'h0, st.die, st.cfg, st.lock};
				default:            n.pslverr = 1'h1;
			endcase
		end

		// apb access phase effects
		if (apb_acc)
		begin
			if (pwrite && paddr == snf_pkg::REG_CTRL)
				n.hold_en = pwdata[0]; // [RULE9]
			if (pwrite && paddr == snf_pkg::REG_ACOL)
				n.acol = (pwdata[11:0] >= snf_pkg::PAGE_BYTES) ? 12'h000 : pwdata[11:0];
			if (paddr == snf_pkg::REG_ADATA)
				n.acol = next_col(st.acol);
			if (pwrite && paddr == snf_pkg::REG_DONE && pwdata[0])
			begin
				n.oip = 1'h0;
				n.aop = snf_pkg::AOP_NONE;
			end
			if (pwrite && paddr == snf_pkg::REG_DONE && pwdata[1])
				n.p_fail = 1'h1;
		end

		// hold control, only while selected and enabled
		if (!sel || !n.hold_en)
		begin
			n.hold_act      = 1'h0; // [RULE9] [RULE10]
			n.hold_on_pend  = 1'h0;
			n.hold_off_pend = 1'h0;
		end
		else if (!(st.phase == snf_pkg::PH_DOUT && st.w == 3'h4))
		begin
			if (hold_fall && !st.sck_s2)
				n.hold_act = 1'h1; // [RULE11]
			else if (hold_fall)
				n.hold_on_pend = 1'h1; // [RULE11]
			if (hold_rise && !st.sck_s2)
			begin
				n.hold_act     = 1'h0; // [RULE12]
				n.hold_on_pend = 1'h0;
			end
			else if (hold_rise && st.hold_on_pend)
				n.hold_on_pend = 1'h0;
			else if (hold_rise)
				n.hold_off_pend = 1'h1; // [RULE12]
			if (sck_fall && st.hold_on_pend)
			begin
				n.hold_act     = 1'h1; // [RULE11]
				n.hold_on_pend = 1'h0;
			end
			if (sck_fall && st.hold_off_pend)
			begin
				n.hold_act      = 1'h0; // [RULE12]
				n.hold_off_pend = 1'h0;
			end
		end

		// frame control
		if (cs_fall)
			n.armed = 1'h1; // [RULE1]
		if (cs_rise)
		begin
			n.phase     = snf_pkg::PH_CMD; // [RULE25]
			n.bitcnt    = 4'h0;
			n.ocnt      = 4'h0;
			n.w         = 3'h1;
			n.exec_pend = 1'h0;
			if (st.exec_pend && !st.oip && st.op == snf_pkg::OP_PRD)
			begin
				n.oip = 1'h1; // [RULE20]
				n.aop = snf_pkg::AOP_LOAD;
				n.row = st.addr;
			end
			else if (st.exec_pend && !st.oip)
			begin
				if (!st.wel || (st.cfg[snf_pkg::OTP_BIT] && st.addr >= snf_pkg::OTP_PAGES))
					n.p_fail = 1'h1; // [RULE21]
				else
				begin
					n.oip    = 1'h1;
					n.aop    = snf_pkg::AOP_PROG;
					n.row    = st.addr;
					n.p_fail = 1'h0;
					n.wel    = 1'h0;
				end
			end
		end
		else if (live && sck_rise)
		begin
			// rising clock: sample lanes
			n.sh     = nb; // [RULE3]
			n.bitcnt = st.bitcnt + {1'h0, st.w};
			unique case (st.phase)
				snf_pkg::PH_CMD:
				begin
					if (byte_done)
					begin
						n.bitcnt = 4'h0;
						n.op     = nb;
						n.phase  = snf_pkg::PH_ADDR;
						unique case (nb)
							snf_pkg::OP_WREN: begin n.wel = 1'h1; n.phase = snf_pkg::PH_SKIP; end
							snf_pkg::OP_WRDI: begin n.wel = 1'h0; n.phase = snf_pkg::PH_SKIP; end
							snf_pkg::OP_GETF, snf_pkg::OP_SETF: n.abytes = 2'h1;
							snf_pkg::OP_RD1, snf_pkg::OP_RD1F, snf_pkg::OP_RD2, snf_pkg::OP_RD4,
							snf_pkg::OP_PL1, snf_pkg::OP_PL4: n.abytes = 2'h2;
							snf_pkg::OP_PRD, snf_pkg::OP_PEX: n.abytes = 2'h3;
							default: n.phase = snf_pkg::PH_SKIP;
						endcase
					end
				end
				snf_pkg::PH_ADDR:
				begin
					if (byte_done)
					begin
						n.bitcnt = 4'h0;
						n.addr   = a_full;
						n.abytes = st.abytes - 2'h1;
						if (st.abytes == 2'h1)
						begin
							n.feat  = nb;
							n.col   = (a_full[11:0] >= snf_pkg::PAGE_BYTES) ? 12'h000 : a_full[11:0]; // [RULE17]
							n.phase = snf_pkg::PH_SKIP;
							if (st.op == snf_pkg::OP_GETF)
								n.phase = snf_pkg::PH_DOUT;
							else if (st.op == snf_pkg::OP_SETF)
								n.phase = snf_pkg::PH_DIN;
							else if (st.op == snf_pkg::OP_PL1 || st.op == snf_pkg::OP_PL4)
							begin
								n.phase = snf_pkg::PH_DIN;
								n.w     = width_of(st.op);
							end
							else if (st.op == snf_pkg::OP_PRD || st.op == snf_pkg::OP_PEX)
								n.exec_pend = 1'h1; // [RULE2]
							else
								n.phase = snf_pkg::PH_DUMMY;
						end
					end
				end
				snf_pkg::PH_DUMMY:
				begin
					if (st.bitcnt == 4'h7)
					begin
						n.bitcnt = 4'h0;
						n.ocnt   = 4'h0;
						n.phase  = snf_pkg::PH_DOUT;
						n.w      = width_of(st.op);
					end
				end
				snf_pkg::PH_DIN:
				begin
					if (byte_done && st.op == snf_pkg::OP_SETF)
					begin
						n.bitcnt = 4'h0;
						if (st.feat == snf_pkg::FA_LOCK && lock_frozen)
							n.lock = (st.lock & snf_pkg::LOCK_KEEP_MASK)
								| (nb & ~snf_pkg::LOCK_KEEP_MASK); // [RULE7] [RULE24]
						else if (st.feat == snf_pkg::FA_LOCK)
							n.lock = nb;
						else if (st.feat == snf_pkg::FA_CFG)
							n.cfg = nb; // [RULE14]
						else if (st.feat == snf_pkg::FA_DIE)
							n.die = nb; // [RULE19]
					end
					else if (byte_done)
					begin
						n.bitcnt  = 4'h0;
						n.wr_pend = 1'h1; // [RULE20]
						n.wr_col  = st.col;
						n.wr_data = nb;
						n.col     = next_col(st.col);
					end
				end
				snf_pkg::PH_DOUT, snf_pkg::PH_SKIP: n.bitcnt = st.bitcnt;
			endcase
		end
		else if (live && sck_fall && st.phase == snf_pkg::PH_DOUT)
		begin
			// falling clock: present next lane bits
			if (st.ocnt == 4'h0)
			begin
				n.lane_out = lanes_of(ob, st.w); // [RULE3]
				n.osh      = ob << st.w;
				n.ocnt     = 4'h8 - {1'h0, st.w};
				if (st.op != snf_pkg::OP_GETF)
					n.col = next_col(st.col);
			end
			else
			begin
				n.lane_out = lanes_of(st.osh, st.w); // [RULE3]
				n.osh      = st.osh << st.w;
				n.ocnt     = st.ocnt - {1'h0, st.w};
			end
		end

		// lane direction follows the phase that is being entered
		n.lane_oe_n = 4'hf; // [RULE5] [RULE13]
		if (sel && !n.hold_act && n.phase == snf_pkg::PH_DOUT)
		begin
			unique case (n.w)
				3'h4:    n.lane_oe_n = 4'h0; // [RULE26]
				3'h2:    n.lane_oe_n = 4'hc; // [RULE26]
				default: n.lane_oe_n = 4'hd;
			endcase
		end
		n.standby = st.cs_s2 & ~st.oip; // [RULE6]
	end

	// ************************************************************
	// state register, power-up starts first-page load
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st           <= '0; // select chain starts low, no false fall [RULE1]
			st.ln_s1     <= 4'hf;
			st.ln_s2     <= 4'hf;
			st.hold_q    <= 1'h1;
			st.phase     <= snf_pkg::PH_CMD;
			st.w         <= 3'h1;
			st.lock      <= snf_pkg::LOCK_RST;
			st.cfg       <= snf_pkg::CFG_RST; // [RULE14]
			st.die       <= snf_pkg::DIE_RST;
			st.oip       <= 1'h1; // [RULE22]
			st.aop       <= snf_pkg::AOP_LOAD; // [RULE22]
			st.lane_oe_n <= 4'hf;
		end
		else
			st <= n;
	end

	assign lane_out  = st.lane_out;
	assign lane_oe_n = st.lane_oe_n;
	assign standby   = st.standby;
	assign prdata    = st.prdata;
	assign pready    = st.pready;
	assign pslverr   = st.pslverr;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_desel_hiz;
		st.cs_s2 && st.cs_q |=> lane_oe_n == 4'hf;
	endproperty
	a_desel_hiz: assert property (p_desel_hiz) // [RULE5]
		else $error("lanes driven while deselected");

	property p_unarmed;
		!st.armed |-> st.phase == snf_pkg::PH_CMD && st.bitcnt == 4'h0;
	endproperty
	a_unarmed: assert property (p_unarmed) // [RULE1]
		else $error("command decoded before first select edge");

	property p_hold_hiz;
		st.hold_act |=> lane_oe_n == 4'hf;
	endproperty
	a_hold_hiz: assert property (p_hold_hiz) // [RULE10]
		else $error("lanes driven during hold");

	property p_hold_default;
		!st.hold_en |-> !st.hold_act && !st.hold_on_pend;
	endproperty
	a_hold_default: assert property (p_hold_default) // [RULE9]
		else $error("hold active while disabled");

	property p_lock_frozen;
		lock_wr_try && lock_frozen |=> st.lock[7:2] == $past(st.lock[7:2]);
	endproperty
	a_lock_frozen: assert property (p_lock_frozen) // [RULE24]
		else $error("protected lock bits changed");

	property p_frame_end;
		cs_rise |=> st.phase == snf_pkg::PH_CMD && st.bitcnt == 4'h0 && !st.exec_pend;
	endproperty
	a_frame_end: assert property (p_frame_end) // [RULE25]
		else $error("frame not discarded on select rise");

	property p_standby;
		st.cs_s2 && !st.oip |=> standby;
	endproperty
	a_standby: assert property (p_standby) // [RULE6]
		else $error("no standby when idle and deselected");

	property p_lane_dir;
		lane_oe_n != 4'hf |-> st.phase == snf_pkg::PH_DOUT && !st.hold_act;
	endproperty
	a_lane_dir: assert property (p_lane_dir) // [RULE26]
		else $error("lanes driven outside read data");

	property p_bus_answer;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer not one cycle after setup");

endmodule
`default_nettype wire

/* snf_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host serial controller model, mode 0
// ****************************************
module snf_host (
	output var  logic       cs_n,
	output var  logic       sck,
	output var  logic [3:0] drv,
	output var  logic [3:0] drv_en,
	input  wire logic [3:0] pin
);
	// idle: deselected, clock low, write protect and hold high
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		drv = 4'hc;
		drv_en = 4'hd;
	end

	// one clock: lane0 set up, rise, sample late in the high phase
	task automatic clk(input logic b, output logic [3:0] s);
	begin
		drv[0] <= b;
		#100 sck <= 1'b1;
		#90 s = pin;
		#10 sck <= 1'b0;
	end
	endtask

	// whole frame: n command bits, dummy clocks, nrd bytes on w lanes
	task automatic frame(input logic [31:0] c, input int n, input int dum,
		input int nrd, input int w, output logic [15:0] rd);
		logic [3:0] s;
	begin
		cs_n <= 1'b0;
		rd = 16'h0000;
		#100;
		for (int i = n - 1; i >= 0; i--)
			clk(c[i], s);
		drv_en <= (w == 4) ? 4'h0 : (w == 2) ? 4'hc : 4'hd;
		for (int i = 0; i < dum; i++)
			clk(1'b0, s);
		for (int i = 0; i < nrd * 8 / w; i++)
		begin
			clk(1'b0, s);
			rd = (w == 4) ? {rd[11:0], s} : (w == 2) ? {rd[13:0], s[1:0]} : {rd[14:0], s[1]};
		end
		#100 cs_n <= 1'b1;
		drv_en <= 4'hd;
		// deselect gap so that back-to-back frames show a select rise
		#200;
	end
	endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench for the serial front end
// ****************************************
module tb;
	typedef struct packed {
		logic [31:0] c;
		logic [7:0]  n;
		logic [7:0]  a;
		logic [31:0] e;
		logic [31:0] m;
	} snf_row_t;
	logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, standby, cs_n, sck, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  lane_in, lane_out, lane_oe_n, drv, drv_en, s;
	logic [15:0] rd;
	int          n_mismatch, n_compared, cyc;
	// frame, register read, expected, mask
	snf_row_t    rows [6] = '{
		'{32'h06, 8'h08, snf_pkg::REG_DONE, 32'h2, 32'h7},
		'{32'h04, 8'h08, snf_pkg::REG_DONE, 32'h0, 32'h7},
		'{32'h1fb000, 8'h18, snf_pkg::REG_STAT, 32'h0, 32'h40}, // host owns ecc
		'{32'h1fb010, 8'h18, snf_pkg::REG_STAT, 32'h40, 32'h40},
		'{32'h1fd040, 8'h18, snf_pkg::REG_STAT, 32'h200, 32'h600},
		'{32'h1fd000, 8'h18, snf_pkg::REG_STAT, 32'h0, 32'h600}};

	snf_front uut (.sys_clk, .reset_n, .cs_n, .sck, .lane_in, .lane_out, .lane_oe_n, .standby,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	snf_host host (.cs_n, .sck, .drv, .drv_en, .pin(lane_in));

	// pin level: device, else host, else pull-up or flipped last value
	always_comb
		for (int i = 0; i < 4; i++)
			lane_in[i] = !lane_oe_n[i] ? lane_out[i] : drv_en[i] ? drv[i] : (i > 1 || !drv[i]);

	always #12.5 sys_clk = ~sys_clk;

	task automatic conclude;
	begin
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask

	// one apb transfer after the pins have settled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		repeat (4) @(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	// hang guard
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	initial
	begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		n_mismatch = 0;
		n_compared = 0;
		cyc = 0;
		#1 host.cs_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		// reset values and unmapped offset
		chk(standby, 32'h0);
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h7f8, 32'h58);
		apb(1'b0, snf_pkg::REG_FEAT, 32'h0);
		chk(r, 32'h1000);
		apb(1'b0, snf_pkg::REG_CTRL, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk({r[30:0], e}, 32'h1);
		// select low since reset: opcode must be ignored
		for (int i = 7; i >= 0; i--)
			host.clk(snf_pkg::OP_WREN[i], s);
		apb(1'b0, snf_pkg::REG_DONE, 32'h0);
		chk(r & 32'h7, 32'h1);
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h2, 32'h0);
		host.cs_n <= 1'b1;
		// finish power-up load
		apb(1'b1, snf_pkg::REG_DONE, 32'h1);
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h38, 32'h0);
		chk(standby, 32'h1);
		// partial opcode dropped, then status read
		host.frame(32'h06, 7, 0, 0, 1, rd);
		host.frame(32'h0fc0, 16, 0, 1, 1, rd);
		chk(rd, 32'h0);
		foreach (rows[i])
		begin
			host.frame(rows[i].c, rows[i].n, 0, 0, 1, rd);
			apb(1'b0, rows[i].a, 32'h0);
			chk(r & rows[i].m, rows[i].e);
		end
		// lock frozen under write protect
		host.frame(32'h1fa0bc, 24, 0, 0, 1, rd);
		host.drv[2] <= 1'b0;
		host.frame(32'h1fa000, 24, 0, 0, 1, rd);
		host.drv[2] <= 1'b1;
		host.frame(32'h0fa0, 16, 0, 1, 1, rd);
		chk(rd, 32'hbc);
		// cache read on one, two and four lanes
		apb(1'b1, snf_pkg::REG_ACOL, 32'h0);
		apb(1'b1, snf_pkg::REG_ADATA, 32'ha5);
		apb(1'b1, snf_pkg::REG_ADATA, 32'h3c);
		for (int k = 0; k < 3; k++)
		begin
			host.frame({8'h0, (k == 0) ? snf_pkg::OP_RD1F : (k == 1) ? snf_pkg::OP_RD2 :
				snf_pkg::OP_RD4, 16'h0}, 24, 8, 2, 1 << k, rd);
			chk(rd, 32'ha53c);
		end
		repeat (6) @(posedge sys_clk);
		chk(lane_oe_n, 32'hf);
		// one byte loaded over the link, then programmed
		host.frame(32'h02000555, 32, 0, 0, 1, rd);
		apb(1'b1, snf_pkg::REG_ACOL, 32'h5);
		apb(1'b0, snf_pkg::REG_ADATA, 32'h0);
		chk(r & 32'hff, 32'h55);
		host.frame(32'h06, 8, 0, 0, 1, rd);
		host.frame(32'h10000005, 32, 0, 0, 1, rd);
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h38, 32'h28);
		apb(1'b1, snf_pkg::REG_DONE, 32'h1);
		// page read to plane one keeps the part busy
		host.frame(32'h13000040, 32, 0, 0, 1, rd);
		apb(1'b0, snf_pkg::REG_ROW, 32'h0);
		chk(r, 32'h40);
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h138, 32'h118);
		chk(standby, 32'h0);
		apb(1'b1, snf_pkg::REG_DONE, 32'h1);
		// hold: disabled, enabled, released, deselected
		host.cs_n <= 1'b0;
		host.drv[3] <= 1'b0;
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h4, 32'h0);
		host.drv[3] <= 1'b1;
		apb(1'b1, snf_pkg::REG_CTRL, 32'h1);
		host.drv[3] <= 1'b0;
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h4, 32'h4);
		chk(lane_oe_n, 32'hf);
		host.drv[3] <= 1'b1;
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h4, 32'h0);
		host.cs_n <= 1'b1;
		host.drv[3] <= 1'b0;
		apb(1'b0, snf_pkg::REG_STAT, 32'h0);
		chk(r & 32'h4, 32'h0);
		host.drv[3] <= 1'b1;
		// program past the one-time area fails
		host.frame(32'h1fb050, 24, 0, 0, 1, rd);
		host.frame(32'h06, 8, 0, 0, 1, rd);
		host.frame(32'h1000001e, 32, 0, 0, 1, rd);
		apb(1'b0, snf_pkg::REG_DONE, 32'h0);
		chk(r & 32'h4, 32'h4);
		conclude();
	end
endmodule
`default_nettype wire
